// *** core/acms_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - mode comes from config bits 6:5; 00 one-shot, 01 repeat, 11 repeat-sweep.
// - one-shot converts the selected channel once per trigger into the buffer.
// - one-shot gives one end-of-conversion or interrupt per conversion.
// - normal one-shot: select or frame sync starts select, sample, convert, read.
// - extended one-shot: select for channel and readout, start pin converts.
// - repeat converts the same channel, triggered by select or frame sync.
// - buffered modes raise one interrupt when stored count reaches threshold.
// - repeat modes continue with the same selection after threshold is read.
// - repeat modes discard the buffer if the next cycle is not a read.
// - sweep converts each channel of the sequence once into the buffer.
// - extended buffered modes trigger from start pin while select is high.
// - end-of-conversion pin choice only works in one-shot, else interrupt.
// - code 10 is sweep, visiting sequence channels in order into buffer.
// - sweep (code 10) stops filling at threshold even with sequence unfinished.
module acms_sequencer
  import acms_pkg::*;
(
  input wire logic mclk, // 40 MHz clock
  input wire logic srst, // sync reset, high
  input wire logic [acms_pkg::CFG_W-1:0] config_word, // configuration word
  input wire logic extended_sampling, // 1: start pin triggers
  input wire logic eoc_select, // 1: pin acts as end-of-conversion in one-shot
  input wire logic [acms_pkg::CNT_W-1:0] threshold, // buffer threshold, 1..8
  input wire logic [acms_pkg::CH_W-1:0] sel_channel, // selected channel
  input wire logic [acms_pkg::CH_W-1:0] sweep_len, // sweep sequence length
  input wire logic [acms_pkg::CH_W-1:0] sweep_step, // channel step in sweep
  input wire logic cycle_is_read, // current host cycle is a buffer read
  input wire logic cs_n, // chip select pin, async
  input wire logic frame_sync, // frame sync pin, async
  input wire logic conversion_start_n, // conversion start pin, async
  input wire logic [acms_pkg::DATA_W-1:0] conv_data, // converter result
  output logic conv_busy, // conversion in progress
  output logic [acms_pkg::CH_W-1:0] conv_channel, // channel being converted
  output logic eoc_int_n, // shared pin, low active
  output logic out_valid, // result word available
  input wire logic out_ready, // reader takes result
  output logic [acms_pkg::DATA_W-1:0] out_data, // result word
  output logic [acms_pkg::CNT_W-1:0] stored_cnt // results held
);
  // pin synchronisers
  logic [1:0] cs_s_r, fs_s_r, st_s_r;
  logic cs_d_r, fs_d_r, st_d_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_s_r <= 2'h3;
      fs_s_r <= 2'h0;
      st_s_r <= 2'h3;
      cs_d_r <= 1'b1;
      fs_d_r <= 1'b0;
      st_d_r <= 1'b1;
    end else begin
      cs_s_r <= {cs_s_r[0], cs_n};
      fs_s_r <= {fs_s_r[0], frame_sync};
      st_s_r <= {st_s_r[0], conversion_start_n};
      cs_d_r <= cs_s_r[1];
      fs_d_r <= fs_s_r[1];
      st_d_r <= st_s_r[1];
    end
  end
  logic cs_fall, fs_rise, st_rise, cycle_begin;
  assign cs_fall = cs_d_r & ~cs_s_r[1];
  assign fs_rise = ~fs_d_r & fs_s_r[1];
  assign st_rise = ~st_d_r & st_s_r[1];
  assign cycle_begin = cs_fall | fs_rise;

  logic [1:0] mode;
  assign mode = config_word[MODE_MSB:MODE_LSB];
  logic oneshot, repeat_m, sweep_m;
  assign oneshot = (mode == MODE_ONESHOT);
  assign repeat_m = (mode == MODE_REPEAT) | (mode == MODE_RSWEEP);
  assign sweep_m = (mode == MODE_SWEEP) | (mode == MODE_RSWEEP);

  acms_state_e state_r;
  logic [CONV_W-1:0] conv_cnt_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CH_W-1:0] sweep_idx_r;
  logic int_pend_r, full_r;
  logic trigger;
  // trigger source per sampling type; the start pin counts only with select high,
  // and in normal sampling a buffer read frame carries no conversion of its own
  assign trigger = (state_r == ST_IDLE) & ~full_r &
                   (extended_sampling ? (st_rise & cs_s_r[1])
                                      : (cycle_begin & ~cycle_is_read));
  logic conv_done;
  assign conv_done = (state_r == ST_CONV) & (conv_cnt_r == CONV_W'(CONV_CYC - 1));

  // conversion sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      conv_cnt_r <= CONV_RST;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          conv_cnt_r <= CONV_RST;
          if (trigger) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_cnt_r <= conv_cnt_r + 8'h01;
          if (conv_done) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          state_r <= ST_IDLE; // one conversion per trigger
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign conv_busy = (state_r == ST_CONV);

  // channel: fixed selection or walk through sweep sequence
  always_ff @(posedge mclk) begin
    if (srst) begin
      sweep_idx_r <= CH_RST;
      conv_channel <= CH_RST;
    end else begin
      if (trigger) begin
        conv_channel <= sweep_m ? CH_W'(sel_channel + sweep_idx_r * sweep_step)
                                : sel_channel;
      end
      if (!sweep_m) begin
        sweep_idx_r <= CH_RST;
      end else if (conv_done) begin
        sweep_idx_r <= (sweep_idx_r + 4'h1 >= sweep_len) ? CH_RST : sweep_idx_r + 4'h1;
      end
    end
  end

  // buffer occupancy; one-shot also pushes each result into the buffer
  logic push, pop, discard;
  assign pop = out_valid & out_ready;
  assign push = conv_done;
  // interrupt served by anything but a read clears the buffer in repeat modes
  assign discard = int_pend_r & cycle_begin & ~cycle_is_read & repeat_m;
  logic [DATA_W-1:0] buf_r [DEPTH];
  logic [2:0] wp_r, rp_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= CNT_RST;
      wp_r <= 3'h0;
      rp_r <= 3'h0;
    end else if (discard) begin
      cnt_r <= CNT_RST;
      wp_r <= 3'h0;
      rp_r <= 3'h0;
    end else begin
      if (push && cnt_r < 4'(DEPTH)) begin
        buf_r[wp_r] <= conv_data;
        wp_r <= wp_r + 3'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 3'h1;
      end
      cnt_r <= cnt_r + {3'h0, push && cnt_r < 4'(DEPTH)} - {3'h0, pop};
    end
  end
  assign out_valid = (cnt_r != CNT_RST);
  assign out_data = buf_r[rp_r];
  assign stored_cnt = cnt_r;

  // sweep (code 10) halts at threshold until the buffer is read out;
  // set wins, else a threshold of one would never halt from an empty buffer
  logic [CNT_W-1:0] thr_eff;
  assign thr_eff = oneshot ? 4'h1 : threshold;
  always_ff @(posedge mclk) begin
    if (srst) begin
      full_r <= 1'b0;
    end else if (mode == MODE_SWEEP && push && cnt_r + 4'h1 >= thr_eff) begin
      full_r <= 1'b1;
    end else if (discard || cnt_r == CNT_RST) begin
      full_r <= 1'b0;
    end
  end

  // interrupt: set wins over the clear at the next cycle start
  logic int_set;
  assign int_set = push & ((cnt_r + 4'h1 == thr_eff) | oneshot);
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_pend_r <= 1'b0;
    end else begin
      if (int_set) begin
        int_pend_r <= 1'b1;
      end else if (cycle_begin) begin
        int_pend_r <= 1'b0;
      end
    end
  end

  // eoc option honoured only in one-shot
  always_ff @(posedge mclk) begin
    if (srst) begin
      eoc_int_n <= 1'b1;
    end else if (oneshot && eoc_select) begin
      eoc_int_n <= ~(state_r == ST_CONV && !conv_done);
    end else begin
      eoc_int_n <= ~(int_pend_r | int_set);
    end
  end

  one_int_a: assert property (@(posedge mclk) disable iff (srst)
    int_set |=> int_pend_r) else $error("interrupt not raised");
  conv_len_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(conv_busy) |-> conv_busy [*8]) else $error("conversion too short");
  trig_idle_a: assert property (@(posedge mclk) disable iff (srst)
    trigger |=> state_r == ST_CONV) else $error("trigger not taken");
  ext_src_a: assert property (@(posedge mclk) disable iff (srst)
    extended_sampling && $rose(conv_busy) |-> $past(st_rise)) else $error("bad ext trigger");
  discard_a: assert property (@(posedge mclk) disable iff (srst)
    discard |=> stored_cnt == 4'h0) else $error("buffer not cleared");
  halt_a: assert property (@(posedge mclk) disable iff (srst)
    full_r |-> state_r != ST_CONV || !$rose(conv_busy)) else $error("sweep ran past threshold");
  int_pin_a: assert property (@(posedge mclk) disable iff (srst)
    !oneshot && int_pend_r |=> !eoc_int_n) else $error("pin not interrupt");
  clr_a: assert property (@(posedge mclk) disable iff (srst)
    int_pend_r && cycle_begin && !int_set |=> !int_pend_r) else $error("int not cleared");
  fixed_ch_a: assert property (@(posedge mclk) disable iff (srst)
    trigger && !sweep_m |=> conv_channel == $past(sel_channel)) else $error("channel wrong");
  cv_oneshot: cover property (@(posedge mclk) disable iff (srst) oneshot && int_set);
  cv_thresh: cover property (@(posedge mclk) disable iff (srst) repeat_m && int_set);
  cv_discard: cover property (@(posedge mclk) disable iff (srst) discard);
  cv_halt: cover property (@(posedge mclk) disable iff (srst) $rose(full_r));
endmodule // acms_sequencer
`default_nettype wire

// *** inc/acms_pkg.sv ***
`default_nettype none
package acms_pkg;
  // mode field of the configuration word
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 6;
  localparam int CFG_W = 12;
  localparam logic [1:0] MODE_ONESHOT = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_SWEEP = 2'h2;
  localparam logic [1:0] MODE_RSWEEP = 2'h3;
  // fifo and channel widths
  localparam int DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int CH_W = 4;
  localparam int DATA_W = 12;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CH_W-1:0] CH_RST = 4'h0;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  // conversion time, 3.5 us at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 3500;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_W = 8;
  localparam logic [CONV_W-1:0] CONV_RST = 8'h00;
  // host must retrigger within 2.5 us in extended sampling
  localparam int RETRIG_NS = 2500;
  localparam int RETRIG_CYC = RETRIG_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_HOLD = 2'b10
  } acms_state_e;
endpackage : acms_pkg
`default_nettype wire

// *** test/acms_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module acms_host (
  input wire logic mclk, // bench clock
  input wire logic go, // start one frame
  input wire logic [1:0] kind, // 0 select, 1 sync, 2 start pin
  input wire logic rd, // frame is a buffer read
  output logic cs_n, // select pin
  output logic frame_sync, // sync pin
  output logic conversion_start_n, // start pin
  output logic cycle_is_read, // read flag
  output logic busy // frame under way
);
  // one frame per go; pins held one link period of 8 clocks
  initial begin
    {cs_n, frame_sync, conversion_start_n, cycle_is_read, busy} = 5'h14;
    forever begin
      @(posedge mclk);
      if (go) begin
        #2 busy = 1'b1;
        cycle_is_read = rd;
        if (kind == 2'h1) frame_sync = 1'b1;
        else cs_n = 1'b0;
        repeat (8) @(posedge mclk);
        #2 {cs_n, frame_sync} = 2'h2;
        if (kind == 2'h2) begin
          // start edge well inside the retrigger window
          repeat (8) @(posedge mclk);
          #2 conversion_start_n = 1'b0;
          repeat (8) @(posedge mclk);
          #2 conversion_start_n = 1'b1;
        end
        repeat (4) @(posedge mclk);
        #2 busy = 1'b0;
      end
    end
  end
endmodule // acms_host
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
  import acms_pkg::*;
  logic mclk, srst, extended_sampling, eoc_select, out_ready, go, rd;
  logic [CFG_W-1:0] config_word;
  logic [CNT_W-1:0] threshold, stored_cnt;
  logic [CH_W-1:0] sel_channel, sweep_len, sweep_step, conv_channel;
  logic [1:0] kind;
  logic [DATA_W-1:0] conv_data, out_data;
  wire logic cs_n, frame_sync, conversion_start_n, cycle_is_read, busy;
  logic conv_busy, eoc_int_n, out_valid;
  int mismatches = 0;
  int n_compared = 0;
  // result word tagged with its channel so order can be judged
  assign conv_data = {8'ha5, conv_channel};
  acms_host acms_host_inst (.mclk(mclk), .go(go), .kind(kind), .rd(rd), .cs_n(cs_n),
    .frame_sync(frame_sync), .conversion_start_n(conversion_start_n),
    .cycle_is_read(cycle_is_read), .busy(busy));
  acms_sequencer acms_sequencer_inst (.mclk(mclk), .srst(srst), .config_word(config_word),
    .extended_sampling(extended_sampling), .eoc_select(eoc_select), .threshold(threshold),
    .sel_channel(sel_channel), .sweep_len(sweep_len), .sweep_step(sweep_step),
    .cycle_is_read(cycle_is_read), .cs_n(cs_n), .frame_sync(frame_sync),
    .conversion_start_n(conversion_start_n), .conv_data(conv_data), .conv_busy(conv_busy),
    .conv_channel(conv_channel), .eoc_int_n(eoc_int_n), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .stored_cnt(stored_cnt));
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    complete_run();
  endtask
  // inputs always move 2 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic frame(input logic [1:0] k, input logic r);
    int i;
    {kind, rd, go} = {k, r, 1'b1};
    tick(1);
    go = 1'b0;
    // busy is judged at the edge, never in the step in which the host moves it
    @(posedge mclk);
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge mclk);
    #2;
    if (busy !== 1'b0) hang();
  endtask
  // bounded wait for the running conversion, then let the push land
  task automatic settle();
    int i;
    tick(8);
    for (i = 0; i < 300 && conv_busy === 1'b1; i++) tick(1);
    if (conv_busy !== 1'b0) hang();
    tick(3);
  endtask
  task automatic one_shot();
    {config_word, sel_channel, eoc_select} = {CFG_RST, 4'h5, 1'b0};
    frame(2'h0, 1'b0);
    `CHK(conv_channel, 4'h5)
    settle();
    `CHK(eoc_int_n, 1'b0)
    eoc_select = 1'b1;
    frame(2'h1, 1'b0);
    `CHK(eoc_int_n, 1'b0)
    settle();
    `CHK(eoc_int_n, 1'b1)
    // extended one-shot: the select frame clears the interrupt, the start pin converts
    {extended_sampling, eoc_select, sel_channel} = {1'b1, 1'b0, 4'h7};
    frame(2'h2, 1'b0);
    `CHK({eoc_int_n, conv_busy, conv_channel}, 6'h37)
    settle();
    `CHK(eoc_int_n, 1'b0)
    extended_sampling = 1'b0;
  endtask
  task automatic repeat_modes();
    int j;
    for (j = 0; j < 2; j++) begin
      config_word = CFG_RST;
      config_word[MODE_MSB:MODE_LSB] = j ? MODE_RSWEEP : MODE_REPEAT;
      {threshold, sweep_len, sweep_step, sel_channel, out_ready} = {16'h2103, 1'b0};
      frame(2'h1, 1'b0);
      settle();
      `CHK(eoc_int_n, 1'b1)
      frame(2'h0, 1'b0);
      settle();
      `CHK({eoc_int_n, stored_cnt}, 5'h02)
      // a read frame after the interrupt drains the words and converts nothing
      out_ready = 1'b1;
      frame(2'h1, 1'b1);
      `CHK({eoc_int_n, stored_cnt, conv_busy}, 6'h20)
      out_ready = 1'b0;
      frame(2'h0, 1'b0);
      settle();
      frame(2'h1, 1'b0);
      settle();
      `CHK({conv_channel, stored_cnt}, 8'h32)
      frame(2'h1, 1'b0);
      settle();
      `CHK({conv_channel, stored_cnt}, 8'h31)
      out_ready = 1'b1;
      tick(3);
      `CHK(out_valid, 1'b0)
    end
  endtask
  // extended sweep: buffer fills to threshold and refuses a third word
  task automatic sweep_ext();
    int i;
    config_word = CFG_RST;
    config_word[MODE_MSB:MODE_LSB] = MODE_SWEEP;
    {extended_sampling, threshold, sel_channel, sweep_len, sweep_step} = {1'b1, 16'h2132};
    out_ready = 1'b0;
    for (i = 0; i < 3; i++) begin
      frame(2'h2, 1'b0);
      settle();
      if (i == 1) `CHK(eoc_int_n, 1'b0)
    end
    // third select frame serviced the interrupt; the halted sweep took no word
    `CHK({eoc_int_n, stored_cnt}, 5'h12)
    frame(2'h2, 1'b1);
    `CHK(out_valid, 1'b1)
    out_ready = 1'b1;
    for (i = 0; i < 2; i++) begin
      `CHK(out_data, {8'ha5, 4'h1 + 4'(2 * i)})
      tick(1);
    end
    `CHK(out_valid, 1'b0)
    out_ready = 1'b0;
    frame(2'h2, 1'b0);
    settle();
    `CHK(stored_cnt, 4'h1)
    `CHK(out_data, {8'ha5, 4'h5})
  endtask
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // reset, then the scenarios in turn
  initial begin
    {srst, config_word, extended_sampling, eoc_select} = {1'b1, CFG_RST, 2'h0};
    {threshold, sel_channel, sweep_len, sweep_step} = 16'h1010;
    {out_ready, go, kind, rd} = 5'h10;
    tick(10);
    srst = 1'b0;
    tick(2);
    one_shot();
    repeat_modes();
    sweep_ext();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
